// ==== verilog/fpme_pkg.sv ====
`default_nettype none
package fpme_pkg;
   // ==========================================================
   // timing
   localparam int unsigned CLOCK_HZ = 50000000;
   localparam int unsigned PROG_MIN_MS = 1;
   localparam int unsigned PROG_MAX_MS = 3000;
   localparam int unsigned ERASE_MIN_MS = 100;
   localparam int unsigned ERASE_MAX_MS = 40000;
   localparam longint unsigned CYC_PER_MS = longint'(CLOCK_HZ) / 64'd1000;
   localparam logic [31:0] PROG_MIN_CYC = 32'(longint'(PROG_MIN_MS) * CYC_PER_MS);
   localparam logic [31:0] PROG_MAX_CYC = 32'(longint'(PROG_MAX_MS) * CYC_PER_MS);
   localparam logic [31:0] ERASE_MIN_CYC = 32'(longint'(ERASE_MIN_MS) * CYC_PER_MS);
   localparam logic [31:0] ERASE_MAX_CYC = 32'(longint'(ERASE_MAX_MS) * CYC_PER_MS);
   // ==========================================================
   // page and commands
   localparam int PAGE_BYTES = 128;
   localparam logic [6:0] PAGE_LAST = 7'h7F;
   localparam logic [7:0] PAGE_OFS_LO = 8'h00;
   localparam logic [7:0] PAGE_OFS_HI = 8'h80;
   localparam logic [7:0] CMD_READ = 8'h00;
   localparam logic [7:0] CMD_PROG = 8'h40;
   localparam logic [7:0] CMD_ERASE = 8'h20;
   localparam logic [7:0] CMD_STATUS = 8'h71;
   // ==========================================================
   // status byte fields
   localparam int ST_ABNORMAL = 7;
   localparam int ST_CMD_ERR = 6;
   localparam int ST_PROG_ERR = 5;
   localparam int ST_ERASE_ERR = 4;
   localparam int ST_COUNT = 1;
   localparam int ST_BAD_ADDR = 0;
   localparam int POLL_DONE = 7;
   localparam int POLL_OK = 6;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   // ==========================================================
   typedef enum logic [3:0] {
      S_READ = 4'h0,
      S_WAIT = 4'h1,
      S_PGM_LOAD = 4'h2,
      S_PGM_RUN = 4'h3,
      S_ERS_CMD2 = 4'h4,
      S_ERS_RUN = 4'h5,
      S_STS_CMD2 = 4'h6,
      S_POLL = 4'h7,
      S_STATUS = 4'h8
   } fpme_state_t;
   typedef struct packed {
      logic ce_n;
      logic oe_n;
      logic we_n;
      logic flash_write_permit_pin;
      logic [17:0] addr;
      logic [7:0] data;
   } fpme_pins_t;
   typedef struct packed {
      logic done;
      logic fail;
      logic count_exceeded;
      logic [7:0] rdata;
   } fpme_array_rsp_t;
endpackage : fpme_pkg
`default_nettype wire

// ==== verilog/fpme_engine.sv ====
// Contract
// - a program operation writes one 128-byte page from 128 consecutive data writes.
// - page address low byte must be 00 or 80; else program anyway, flag error.
// - poll bits 7 and 6 held until next command write, returned on reads.
// - erase covers the whole array only.
// - status read reports why an operation ended abnormally.
// - status byte holds until a command selecting another mode.
// - status bit7 abnormal end; bits 6,5,4 command, program, erase error.
// - status bit1 count exceeded, bit0 bad address; all reset to zero.
// - status bits 3 and 2 undefined; driven as zero.
// - poll bit7 reads 0 while running, 1 after any end.
// - poll bit6 is 1 only on normal end; bits 5..0 read 0.
// - program sequence is one command byte plus 128 data bytes.
// - after reset the device is in memory read mode.
// - after an operation the device waits for a command; reads need a read command.
`default_nettype none
module fpme_engine #(
   parameter logic [31:0] PROG_MIN = fpme_pkg::PROG_MIN_CYC,
   parameter logic [31:0] PROG_MAX = fpme_pkg::PROG_MAX_CYC,
   parameter logic [31:0] ERASE_MIN = fpme_pkg::ERASE_MIN_CYC,
   parameter logic [31:0] ERASE_MAX = fpme_pkg::ERASE_MAX_CYC
) (
   input wire logic i_clock,
   input wire logic i_resetn,
   input wire logic i_enable,
   input wire fpme_pkg::fpme_pins_t i_pins,
   input wire fpme_pkg::fpme_array_rsp_t i_array,
   input wire logic [6:0] i_array_idx,
   output logic [7:0] o_data,
   output logic o_data_oe,
   output logic [17:0] o_array_addr,
   output logic [7:0] o_array_wdata,
   output logic o_array_prog,
   output logic o_array_erase
);
   import fpme_pkg::*;

   // ==========================================================
   // strobes
   function automatic logic page_ok(input logic [7:0] lo);
      page_ok = (lo == PAGE_OFS_LO) || (lo == PAGE_OFS_HI);
   endfunction : page_ok

   fpme_state_t state, next_state;
   logic we_q, next_we_q;
   logic [31:0] cnt, next_cnt;
   logic [6:0] idx, next_idx;
   logic [7:0] status, next_status;
   logic [7:0] poll, next_poll;
   logic done_seen, next_done_seen;
   logic [17:0] page_addr, next_page_addr;
   logic [7:0] page [PAGE_BYTES];
   logic [7:0] next_data;
   logic next_oe, next_prog, next_erase;
   logic wr, rd;

   // write taken on the rising edge of the write strobe under chip select
   assign wr = !we_q && i_pins.we_n && !i_pins.ce_n;
   assign rd = !i_pins.ce_n && !i_pins.oe_n && i_pins.we_n;

   // ==========================================================
   // sequencer
   always_comb begin
      logic [31:0] lim_min;
      logic [31:0] lim_max;
      logic run;
      lim_min = (state == S_ERS_RUN) ? ERASE_MIN : PROG_MIN;
      lim_max = (state == S_ERS_RUN) ? ERASE_MAX : PROG_MAX;
      run = (state == S_PGM_RUN) || (state == S_ERS_RUN);
      next_state = state;
      next_we_q = i_pins.we_n;
      next_cnt = cnt;
      next_idx = idx;
      next_status = status;
      next_poll = poll;
      next_done_seen = done_seen;
      next_page_addr = page_addr;
      next_prog = 1'b0;
      next_erase = 1'b0;
      if (run) begin
         // device ends no sooner than the least time, times out at the longest
         next_cnt = cnt + 32'h00000001;
         next_done_seen = done_seen || i_array.done;
         if (cnt >= lim_max - 32'h00000001) begin
            next_state = S_POLL;
            next_poll = 8'h80;
            next_status[ST_ABNORMAL] = 1'b1;
            next_status[ST_COUNT] = 1'b1;
            next_status[(state == S_ERS_RUN) ? ST_ERASE_ERR : ST_PROG_ERR] = 1'b1;
         end else if ((done_seen || i_array.done) && cnt >= lim_min - 32'h00000001) begin
            next_state = S_POLL;
            next_poll = i_array.fail ? 8'h80 : 8'hC0;
            if (i_array.fail || status[ST_BAD_ADDR]) begin
               next_status[ST_ABNORMAL] = 1'b1;
               next_status[(state == S_ERS_RUN) ? ST_ERASE_ERR : ST_PROG_ERR] = 1'b1;
               next_status[ST_COUNT] = i_array.count_exceeded;
               if (status[ST_BAD_ADDR])
                  next_poll = 8'h80;
            end
         end
      end else if (wr) begin
         unique case (state)
            S_PGM_LOAD: begin
               if (idx == 7'h00) begin
                  next_page_addr = i_pins.addr;
                  next_status[ST_BAD_ADDR] = !page_ok(i_pins.addr[7:0]);
               end
               next_idx = idx + 7'h01;
               if (idx == PAGE_LAST) begin
                  next_state = S_PGM_RUN;
                  next_prog = 1'b1;
                  next_cnt = 32'h00000000;
                  next_done_seen = 1'b0;
                  next_poll = ZERO_BYTE;
               end
            end
            S_ERS_CMD2, S_STS_CMD2: begin
               if (state == S_ERS_CMD2 && i_pins.data == CMD_ERASE) begin
                  next_state = S_ERS_RUN;
                  next_erase = 1'b1;
                  next_cnt = 32'h00000000;
                  next_done_seen = 1'b0;
                  next_poll = ZERO_BYTE;
               end else if (state == S_STS_CMD2 && i_pins.data == CMD_STATUS) begin
                  next_state = S_STATUS;
               end else begin
                  next_state = S_WAIT;
                  next_status[ST_ABNORMAL] = 1'b1;
                  next_status[ST_CMD_ERR] = 1'b1;
               end
            end
            default: begin
               // a first command byte; any mode but status read clears the return code
               if (i_pins.data != CMD_STATUS)
                  next_status = ZERO_BYTE;
               next_poll = ZERO_BYTE;
               next_idx = 7'h00;
               if (i_pins.data == CMD_READ)
                  next_state = S_READ;
               else if (i_pins.data == CMD_PROG && i_pins.flash_write_permit_pin)
                  next_state = S_PGM_LOAD;
               else if (i_pins.data == CMD_ERASE && i_pins.flash_write_permit_pin)
                  next_state = S_ERS_CMD2;
               else if (i_pins.data == CMD_STATUS)
                  next_state = S_STS_CMD2;
               else begin
                  next_state = S_WAIT;
                  next_status[ST_ABNORMAL] = 1'b1;
                  next_status[ST_CMD_ERR] = 1'b1;
               end
            end
         endcase
      end
      // undefined bits kept at zero so the byte is deterministic
      next_status[3:2] = 2'b00;
   end

   // ==========================================================
   // read path
   always_comb begin
      next_oe = rd;
      unique case (state)
         S_READ: next_data = i_array.rdata;
         S_STATUS: next_data = status;
         S_PGM_RUN, S_ERS_RUN, S_POLL: next_data = poll;
         default: next_data = ZERO_BYTE;
      endcase
   end

   always_ff @(posedge i_clock) begin
      if (!i_resetn) begin
         state <= S_READ;
         we_q <= 1'b1;
         cnt <= 32'h00000000;
         idx <= 7'h00;
         status <= ZERO_BYTE;
         poll <= ZERO_BYTE;
         done_seen <= 1'b0;
         page_addr <= 18'h00000;
         o_data <= ZERO_BYTE;
         o_data_oe <= 1'b0;
         o_array_addr <= 18'h00000;
         o_array_wdata <= ZERO_BYTE;
         o_array_prog <= 1'b0;
         o_array_erase <= 1'b0;
      end else if (i_enable) begin
         state <= next_state;
         we_q <= next_we_q;
         cnt <= next_cnt;
         idx <= next_idx;
         status <= next_status;
         poll <= next_poll;
         done_seen <= next_done_seen;
         page_addr <= next_page_addr;
         o_data <= next_data;
         o_data_oe <= next_oe;
         o_array_addr <= (state == S_READ) ? i_pins.addr : page_addr;
         o_array_wdata <= page[i_array_idx];
         o_array_prog <= next_prog;
         o_array_erase <= next_erase;
      end
   end

   // page buffer: no reset, every byte is rewritten before each program
   always_ff @(posedge i_clock) begin
      if (i_enable && state == S_PGM_LOAD && wr)
         page[idx] <= i_pins.data;
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_resetn);

   sequence s_last_byte;
      i_enable && state == S_PGM_LOAD && wr && idx == PAGE_LAST;
   endsequence
   sequence s_started;
      state == S_PGM_RUN && o_array_prog;
   endsequence
   property p_page_start;
      s_last_byte |=> s_started;
   endproperty
   a_page_start: assert property (p_page_start) else $error("program not started");
   property p_bad_addr;
      i_enable && state == S_PGM_LOAD && wr && idx == 7'h00 && !page_ok(i_pins.addr[7:0])
         |=> status[ST_BAD_ADDR];
   endproperty
   a_bad_addr: assert property (p_bad_addr) else $error("bad page address not flagged");
   property p_run_busy;
      (state == S_PGM_RUN || state == S_ERS_RUN) |-> !poll[POLL_DONE] && !poll[POLL_OK];
   endproperty
   a_run_busy: assert property (p_run_busy) else $error("poll shows done while running");
   property p_poll_low;
      poll[5:0] == 6'h00 && (state != S_POLL || poll[POLL_DONE]);
   endproperty
   a_poll_low: assert property (p_poll_low) else $error("poll byte malformed");
   property p_status_hold;
      i_enable && state == S_STATUS && !wr |=> $stable(status);
   endproperty
   a_status_hold: assert property (p_status_hold) else $error("status byte changed");
   property p_abnormal;
      state == S_POLL && !poll[POLL_OK] |-> status[ST_ABNORMAL];
   endproperty
   a_abnormal: assert property (p_abnormal) else $error("abnormal end not reported");
   property p_prog_min;
      i_enable && state == S_PGM_RUN && cnt < PROG_MIN - 32'h00000001 |=> state == S_PGM_RUN;
   endproperty
   a_prog_min: assert property (p_prog_min) else $error("program ended too early");
   property p_poll_read;
      i_enable && state == S_POLL && rd |=> o_data_oe && o_data == $past(poll);
   endproperty
   a_poll_read: assert property (p_poll_read) else $error("poll byte not returned");
   property p_decode;
      i_enable && (state == S_WAIT || state == S_READ) && wr && i_pins.data == CMD_PROG
         && i_pins.flash_write_permit_pin |=> state == S_PGM_LOAD && idx == 7'h00;
   endproperty
   a_decode: assert property (p_decode) else $error("program command not decoded");
   property p_reset_read;
      !i_resetn |=> state == S_READ;
   endproperty
   a_reset_read: assert property (disable iff (1'b0) p_reset_read)
      else $error("not in read mode after reset");
endmodule : fpme_engine
`default_nettype wire

// ==== verif/fpme_prog_model.sv ====
`default_nettype none
module fpme_prog_model (
   input wire logic i_clock,
   input wire logic [7:0] i_data,
   input wire logic i_data_oe,
   output var fpme_pkg::fpme_pins_t o_pins
);
   timeunit 1ns;
   timeprecision 1ps;
   import fpme_pkg::*;
   // scaled stand-in for the gap after a status command
   localparam int STS_GAP = 2;
   initial begin
      o_pins = '{1'b1, 1'b1, 1'b1, 1'b0, 18'h0, 8'h5A};
   end
   // ==========================================================
   // bus cycles
   task automatic wr(input logic [17:0] a, input logic [7:0] d, input logic perm);
      @(posedge i_clock);
      #1;
      o_pins = '{1'b0, 1'b1, 1'b0, perm, a, d};
      @(posedge i_clock);
      #1;
      o_pins.we_n = 1'b1;
      @(posedge i_clock);
      #1;
      // released bus must not keep showing the byte
      o_pins = '{1'b1, 1'b1, 1'b1, perm, 18'h0, ~d};
   endtask : wr
   task automatic rd(output logic [7:0] d, output logic oe);
      @(posedge i_clock);
      #1;
      o_pins.ce_n = 1'b0;
      o_pins.oe_n = 1'b0;
      repeat (2) @(posedge i_clock);
      #1;
      d = i_data;
      oe = i_data_oe;
      o_pins.ce_n = 1'b1;
      o_pins.oe_n = 1'b1;
   endtask : rd
   // ==========================================================
   // command sequences
   task automatic page(input logic [17:0] a, input logic [7:0] q[$]);
      wr(18'h0, CMD_PROG, 1'b1);
      foreach (q[k]) begin
         wr((k == 0) ? a : 18'h0, q[k], 1'b1);
      end
   endtask : page
   task automatic erase();
      wr(18'h0, CMD_ERASE, 1'b1);
      wr(18'h0, CMD_ERASE, 1'b1);
   endtask : erase
   task automatic status();
      wr(18'h0, CMD_STATUS, 1'b1);
      wr(18'h0, CMD_STATUS, 1'b1);
      repeat (STS_GAP) @(posedge i_clock);
   endtask : status
endmodule : fpme_prog_model
`default_nettype wire

// ==== verif/flash_programmer_mode_engine_bench.sv ====
`default_nettype none
module flash_programmer_mode_engine_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import fpme_pkg::*;
   localparam logic [31:0] P_MIN = 32'h14;
   localparam logic [31:0] P_MAX = 32'h190;
   localparam logic [31:0] E_MIN = 32'h28;
   localparam logic [31:0] E_MAX = 32'h258;
   logic i_clock;
   logic i_resetn;
   logic i_enable;
   fpme_pins_t pins;
   fpme_array_rsp_t arr;
   logic [6:0] idx;
   logic [7:0] o_data;
   logic [7:0] o_array_wdata;
   logic o_data_oe;
   logic o_array_prog;
   logic o_array_erase;
   logic [17:0] o_array_addr;
   int error_cnt = 0;
   int n_checks = 0;
   int cyc = 0;
   int prog_n = 0;
   int ers_n = 0;
   logic [7:0] page_q[$];
   logic [7:0] rv;
   logic roe;
   logic [16:0] errs [5];
   fpme_engine #(.PROG_MIN(P_MIN), .PROG_MAX(P_MAX), .ERASE_MIN(E_MIN), .ERASE_MAX(E_MAX)) dut (
      .i_clock(i_clock), .i_resetn(i_resetn), .i_enable(i_enable), .i_pins(pins),
      .i_array(arr), .i_array_idx(idx), .o_data(o_data), .o_data_oe(o_data_oe),
      .o_array_addr(o_array_addr), .o_array_wdata(o_array_wdata),
      .o_array_prog(o_array_prog), .o_array_erase(o_array_erase));
   fpme_prog_model prog (.i_clock(i_clock), .i_data(o_data), .i_data_oe(o_data_oe),
      .o_pins(pins));
   initial begin
      i_clock = 1'b0;
      forever #10 i_clock = ~i_clock;
   end
   // counting pulse cycles also proves each start pulse is one cycle wide
   always @(posedge i_clock) begin
      cyc <= cyc + 1;
      prog_n <= prog_n + int'(o_array_prog === 1'b1);
      ers_n <= ers_n + int'(o_array_erase === 1'b1);
   end
   // ==========================================================
   // checking
   task automatic chk(input logic [17:0] got, input logic [17:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk
   task automatic rdchk(input logic [7:0] exp, input string what);
      prog.rd(rv, roe);
      chk(18'(roe), 18'h1, "bus drive");
      chk(18'(rv), 18'(exp), what);
   endtask : rdchk
   function automatic logic [7:0] sts(input bit a, c, p, e, x, b);
      return {a, c, p, e, 2'b00, x, b};
   endfunction : sts
   task automatic print_verdict();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : print_verdict
   // ==========================================================
   // array side: waits out the whole run before any new command
   task automatic run_op(input int lim, input int done_at, input bit fl, input bit cx,
      input bit deep);
      int base;
      int n;
      int t0;
      base = prog_n + ers_n;
      n = 0;
      while (prog_n + ers_n == base && n < 50) begin
         @(posedge i_clock);
         n++;
      end
      chk(18'(n < 50), 18'h1, "start pulse");
      t0 = cyc;
      repeat (P_MIN) @(posedge i_clock);
      rdchk(8'h00, "poll running");
      if (deep) begin
         chk(o_array_addr, 18'h00100, "page addr");
         for (int k = 0; k < 128; k++) begin
            idx = 7'(k);
            repeat (2) @(posedge i_clock);
            #1;
            chk(18'(o_array_wdata), 18'(page_q[k]), "page byte");
         end
      end
      if (done_at >= 0) begin
         while (cyc - t0 < done_at) @(posedge i_clock);
         #1;
         arr = '{1'b1, fl, cx, arr.rdata};
         @(posedge i_clock);
         #1;
         arr = '{1'b0, 1'b0, 1'b0, arr.rdata};
         repeat (8) @(posedge i_clock);
      end else begin
         while (cyc - t0 < lim - 20) @(posedge i_clock);
         rdchk(8'h00, "poll before limit");
         repeat (30) @(posedge i_clock);
      end
   endtask : run_op
   initial begin
      repeat (100000) @(posedge i_clock);
      error_cnt++;
      $display("[ERR] %0t run hung", $time);
      print_verdict();
   end
   // ==========================================================
   // scenarios
   initial begin
      i_resetn = 1'b0;
      i_enable = 1'b1;
      idx = 7'h00;
      arr = '0;
      errs = '{{8'h55, 8'h00, 1'b1}, {8'h40, 8'h00, 1'b0}, {8'h20, 8'h00, 1'b0},
         {8'h20, 8'h21, 1'b1}, {8'h71, 8'h72, 1'b1}};
      void'($urandom(44));
      arr.rdata = 8'($urandom);
      repeat (3) @(posedge i_clock);
      #1;
      i_resetn = 1'b1;
      rdchk(arr.rdata, "read mode");
      for (int k = 0; k < 128; k++) begin
         page_q.push_back((k < 100) ? 8'($urandom) : 8'hFF);
      end
      prog.page(18'h00100, page_q);
      run_op(int'(P_MAX), 300, 1'b0, 1'b0, 1'b1);
      rdchk(8'hC0, "poll ok");
      // frozen clock enable must not disturb the held poll flags
      i_enable = 1'b0;
      repeat (5) @(posedge i_clock);
      #1;
      i_enable = 1'b1;
      rdchk(8'hC0, "poll held");
      prog.status();
      rdchk(sts(0, 0, 0, 0, 0, 0), "status ok");
      prog.page(18'h00140, page_q);
      run_op(int'(P_MAX), 40, 1'b0, 1'b0, 1'b0);
      rdchk(8'h80, "poll bad addr");
      prog.status();
      rdchk(sts(1, 0, 1, 0, 0, 1), "status bad addr");
      prog.status();
      rdchk(sts(1, 0, 1, 0, 0, 1), "status kept");
      prog.erase();
      run_op(int'(E_MAX), 60, 1'b0, 1'b0, 1'b0);
      rdchk(8'hC0, "poll erase");
      prog.status();
      rdchk(sts(0, 0, 0, 0, 0, 0), "status cleared");
      prog.page(18'h00200, page_q);
      run_op(int'(P_MAX), 40, 1'b1, 1'b1, 1'b0);
      rdchk(8'h80, "poll fail");
      prog.status();
      rdchk(sts(1, 0, 1, 0, 1, 0), "status prog fail");
      prog.erase();
      run_op(int'(E_MAX), -1, 1'b0, 1'b0, 1'b0);
      rdchk(8'h80, "poll erase limit");
      prog.status();
      rdchk(sts(1, 0, 0, 1, 1, 0), "status erase limit");
      foreach (errs[k]) begin
         prog.wr(18'h0, errs[k][16:9], errs[k][0]);
         if (errs[k][8:1] != 8'h00) begin
            prog.wr(18'h0, errs[k][8:1], 1'b1);
         end
         rdchk(8'h00, "wait state read");
         prog.status();
         rdchk(sts(1, 1, 0, 0, 0, 0), "cmd error");
      end
      prog.wr(18'h0, CMD_READ, 1'b0);
      rdchk(arr.rdata, "read after cmd");
      chk(18'(prog_n), 18'h3, "program pulses");
      chk(18'(ers_n), 18'h2, "erase pulses");
      print_verdict();
   end
endmodule : flash_programmer_mode_engine_bench
`default_nettype wire
